// >>> rtl/rtc_regs_pkg.sv
package rtc_regs_pkg;

   // ------------------------------------------------------------
   // Register offsets
   // ------------------------------------------------------------
   localparam logic [3:0] ADDR_SNAP0     = 4'h0;
   localparam logic [3:0] ADDR_SNAP1     = 4'h1;
   localparam logic [3:0] ADDR_SNAP2     = 4'h2;
   localparam logic [3:0] ADDR_SNAP3     = 4'h3;
   localparam logic [3:0] ADDR_CTRL      = 4'h4;
   localparam logic [3:0] ADDR_INT       = 4'h5;
   localparam logic [3:0] ADDR_OSC_CFG   = 4'h6;
   localparam logic [3:0] ADDR_PIN_CFG   = 4'h7;
   localparam logic [3:0] ADDR_WAKE0     = 4'h8;
   localparam logic [3:0] ADDR_WAKE1     = 4'h9;
   localparam logic [3:0] ADDR_WAKE2     = 4'ha;
   localparam logic [3:0] ADDR_WAKE3     = 4'hb;
   localparam logic [3:0] ADDR_INT_MASK  = 4'hc;

   // ------------------------------------------------------------
   // Field positions
   // ------------------------------------------------------------
   localparam int CFG_STEP_EN_BIT  = 7;
   localparam int CFG_SETTLED_BIT  = 6;
   localparam int CTRL_RUN_BIT     = 4;
   localparam int CTRL_WAKE_EN_BIT = 3;
   localparam int CTRL_LOAD_BIT    = 1;
   localparam int CTRL_SNAP_BIT    = 0;
   localparam int INT_ALARM_BIT    = 0;
   localparam int INT_SETTLED_BIT  = 1;
   localparam int INT_WIDTH        = 2;

   // ------------------------------------------------------------
   // Codes and reset values
   // ------------------------------------------------------------
   localparam logic [7:0] PIN_SHORT_CODE  = 8'he7;
   localparam logic [7:0] PIN_NORMAL_CODE = 8'h67;
   localparam logic [3:0] CAP_TARGET_RST  = 4'h0;
   localparam logic [3:0] CAP_STEP_RST    = 4'h0;
   localparam logic [7:0] BYTE_ZERO       = 8'h00;
   localparam logic [31:0] WORD_ZERO      = 32'h0000_0000;
   localparam logic [31:0] WORD_ONE       = 32'h0000_0001;
   localparam logic [3:0] NIBBLE_ONE      = 4'h1;

   // Cycles between two capacitance steps
   localparam int STEP_PERIOD = 4;

endpackage : rtc_regs_pkg

// >>> rtl/cap_stepper.sv
`timescale 1ns/1ps
// Walks the effective load capacitance one code at a time to the target
module cap_stepper #(
   parameter int W      = 4,
   parameter int PERIOD = rtc_regs_pkg::STEP_PERIOD
) (
   // Clock and reset
   input  wire logic         clk_i,
   input  wire logic         rst_b_i,
   // Control
   input  wire logic         step_en_i,
   input  wire logic [W-1:0] target_i,
   // State
   output logic      [W-1:0] cap_o,
   output logic              settled_o
);

   localparam int CW = $clog2(PERIOD + 1);
   localparam logic [CW-1:0] PER_LAST = CW'(PERIOD - 1);

   logic [W-1:0]  cap_reg;
   logic [W-1:0]  cap_next;
   logic [CW-1:0] tick_reg;
   logic [CW-1:0] tick_next;
   logic          tick_done;
   logic          at_target;

   // Pace steps so the oscillator can follow each change
   assign at_target = (cap_reg == target_i);
   assign tick_done = (tick_reg == PER_LAST);
   assign tick_next = (tick_done || at_target || !step_en_i) ? '0
                      : tick_reg + CW'(1);
   // Step toward target only when enabled; hold otherwise
   assign cap_next  = (!step_en_i || at_target || !tick_done) ? cap_reg
                      : (cap_reg < target_i) ? cap_reg + W'(1)
                      : cap_reg - W'(1);                        // RL1

   // Capacitance step state
   always_ff @(posedge clk_i) begin
      if (!rst_b_i) begin
         cap_reg  <= rtc_regs_pkg::CAP_STEP_RST;
         tick_reg <= '0;
      end else begin
         cap_reg  <= cap_next;
         tick_reg <= tick_next;
      end
   end

   assign cap_o     = cap_reg;
   assign settled_o = at_target;                                // RL2

endmodule : cap_stepper

// >>> rtl/rtc_osc_cfg_capture_alarm.sv
`timescale 1ns/1ps
// Overview of operation
// RL1: Config bit 7 set makes hardware step load capacitance toward target.
// RL2: Config bit 6 reads 1 once capacitance equals target, else 0.
// RL3: Config bits 3:0 hold the software target capacitance setting.
// RL4: Config bits 5:4 read zero; writes to them are ignored.
// RL5: Writing 0xe7 to pin config shorts the two crystal pins.
// RL6: Writing 0x67 to pin config restores normal crystal pins.
// RL7: Snapshot bytes 0x00-0x03 form 32-bit timer value, LSB first, reset 0.
// RL8: Load copies snapshot into timer; snapshot copies timer into bytes.
// RL9: Alarm bytes 0x08-0x0b hold 32-bit compare value, reset 0.
// RL10: Software disables alarm before changing compare bytes.
// RL11: Command bit written 1 starts transfer; hardware clears it when done.
// RL12: Enabled alarm fires when timer equals compare value.
module rtc_osc_cfg_capture_alarm (
   // Clock and reset
   input  wire logic       clk_i,
   input  wire logic       rst_b_i,
   // Register port
   input  wire logic [3:0] addr_i,
   input  wire logic [7:0] wdata_i,
   input  wire logic       wr_i,
   input  wire logic       rd_i,
   output logic      [7:0] rdata_o,
   // Oscillator side
   output logic      [3:0] cap_value_o,
   output logic            xtal_short_o,
   // Timer and events
   output logic     [31:0] timer_count_o,
   output logic            alarm_o,
   output logic            irq_o
);

   // ------------------------------------------------------------
   // Register map and timing
   // ------------------------------------------------------------
   // 0x0-0x3  snapshot word; byte 0 holds bits 7:0, byte 3 bits 31:24
   // 0x4      control: run 4, alarm enable 3, alarm flag 2 (read only),
   //          load 1, snapshot 0; bits 7:5 are dropped on write
   // 0x5      event status, write one to clear: settled 1, alarm 0
   // 0x6      oscillator config: step enable 7, settled 6 (read only),
   //          bits 5:4 read zero, target code 3:0
   // 0x7      pin config; any value is kept, only two codes act
   // 0x8-0xb  alarm compare word, same byte order as the snapshot
   // 0xc      event mask, same layout as the status register
   // 0xd-0xf  unmapped: reads return zero, writes are dropped
   //
   // A write lands at the edge that takes it. Read data is registered
   // and stands for the single cycle after the read strobe, zero
   // otherwise, so the host never waits and never sees stale data.
   // A load or snapshot flag reads one for exactly one cycle, the
   // cycle in which the word moves, and the word is in place one
   // cycle later.
   //
   // Every control write rewrites run and alarm enable, so software
   // sets run together with any command it issues.
   // The timer counts on this clock. A slower timer domain would need
   // its own crossing for the load and snapshot words, which is left
   // to the wrapper around this block.
   // The stepper target leaves reset at a fixed code chosen for this
   // block; software is expected to write it before enabling steps.

   // ------------------------------------------------------------
   // Register state
   // ------------------------------------------------------------
   logic [31:0] snap_reg;
   logic [31:0] snap_next;
   logic [31:0] wake_reg;
   logic [31:0] wake_next;
   logic [31:0] timer_reg;
   logic [31:0] timer_next;
   logic        step_en_reg;
   logic [3:0]  target_reg;
   logic [7:0]  pin_cfg_reg;
   logic        short_reg;
   logic        short_next;
   logic        run_reg;
   logic        wake_en_reg;
   logic        load_cmd_reg;
   logic        load_cmd_next;
   logic        snap_cmd_reg;
   logic        snap_cmd_next;
   logic        alarm_reg;
   logic        alarm_next;
   logic [1:0]  int_stat_reg;
   logic [1:0]  int_stat_next;
   logic [1:0]  int_mask_reg;
   logic        settled_d_reg;
   logic [7:0]  rdata_reg;
   logic [7:0]  rdata_next;

   // ------------------------------------------------------------
   // Address decode
   // ------------------------------------------------------------
   // Full four-bit compares keep unmapped indices from aliasing
   wire wr_snap0 = wr_i && (addr_i == rtc_regs_pkg::ADDR_SNAP0);
   wire wr_snap1 = wr_i && (addr_i == rtc_regs_pkg::ADDR_SNAP1);
   wire wr_snap2 = wr_i && (addr_i == rtc_regs_pkg::ADDR_SNAP2);
   wire wr_snap3 = wr_i && (addr_i == rtc_regs_pkg::ADDR_SNAP3);
   wire wr_ctrl  = wr_i && (addr_i == rtc_regs_pkg::ADDR_CTRL);
   wire wr_int   = wr_i && (addr_i == rtc_regs_pkg::ADDR_INT);
   wire wr_cfg   = wr_i && (addr_i == rtc_regs_pkg::ADDR_OSC_CFG);
   wire wr_pin   = wr_i && (addr_i == rtc_regs_pkg::ADDR_PIN_CFG);
   wire wr_wake0 = wr_i && (addr_i == rtc_regs_pkg::ADDR_WAKE0);
   wire wr_wake1 = wr_i && (addr_i == rtc_regs_pkg::ADDR_WAKE1);
   wire wr_wake2 = wr_i && (addr_i == rtc_regs_pkg::ADDR_WAKE2);
   wire wr_wake3 = wr_i && (addr_i == rtc_regs_pkg::ADDR_WAKE3);
   wire wr_mask  = wr_i && (addr_i == rtc_regs_pkg::ADDR_INT_MASK);

   // ------------------------------------------------------------
   // Capacitance stepper
   // ------------------------------------------------------------
   // The stepper paces its changes so the oscillator can follow them.
   // Settled follows the live compare, so a new target drops it in
   // the very next cycle. With stepping off the code freezes where it
   // stands, even away from the target, and settled then stays low.
   // Trade-off: a slow walk to a far code, but no amplitude upset.
   logic [3:0] cap_now;
   logic       settled;

   cap_stepper #(
      .W      (4),
      .PERIOD (rtc_regs_pkg::STEP_PERIOD)
   ) u_stepper (
      .clk_i     (clk_i),
      .rst_b_i   (rst_b_i),
      .step_en_i (step_en_reg),
      .target_i  (target_reg),
      .cap_o     (cap_now),
      .settled_o (settled)
   );

   // ------------------------------------------------------------
   // Commands and timer
   // ------------------------------------------------------------
   // A write of one arms a command; it drops after one transfer cycle
   // Only one transfer of each kind is ever in flight; rewriting a command while
   // its flag is up just repeats the same one-cycle move.
   // Both flags at once is allowed: load and capture then swap words.
   assign load_cmd_next = wr_ctrl ? wdata_i[rtc_regs_pkg::CTRL_LOAD_BIT]
                          : 1'b0;                               // RL11
   assign snap_cmd_next = wr_ctrl ? wdata_i[rtc_regs_pkg::CTRL_SNAP_BIT]
                          : 1'b0;                               // RL11

   // Load beats counting so the loaded value is exact
   // The count wraps silently at the top; no overflow event is kept
   assign timer_next = load_cmd_reg ? snap_reg                  // RL8
                       : run_reg ? timer_reg + rtc_regs_pkg::WORD_ONE
                       : timer_reg;

   // Snapshot capture beats a same-cycle software byte write
   assign snap_next = snap_cmd_reg ? timer_reg                  // RL8
                      : {wr_snap3 ? wdata_i : snap_reg[31:24],
                         wr_snap2 ? wdata_i : snap_reg[23:16],
                         wr_snap1 ? wdata_i : snap_reg[15:8],
                         wr_snap0 ? wdata_i : snap_reg[7:0]};   // RL7

   assign wake_next = {wr_wake3 ? wdata_i : wake_reg[31:24],
                       wr_wake2 ? wdata_i : wake_reg[23:16],
                       wr_wake1 ? wdata_i : wake_reg[15:8],
                       wr_wake0 ? wdata_i : wake_reg[7:0]};     // RL9

   // ------------------------------------------------------------
   // Alarm and interrupt
   // ------------------------------------------------------------
   // Compare only while enabled; software keeps it off during updates
   wire alarm_hit = wake_en_reg && (timer_reg == wake_reg);     // RL12 RL10
   // Disabling the alarm also drops its flag, and wins over a match
   // in the same cycle; the status bit still records that match, so
   // software racing the alarm does not lose the event.
   wire wake_off = wr_ctrl && !wdata_i[rtc_regs_pkg::CTRL_WAKE_EN_BIT];
   // The flag is only ever set while enabled, so holding it needs no
   // second look at the enable
   assign alarm_next = !wake_off && (alarm_hit || alarm_reg);
   wire settle_rise = settled && !settled_d_reg;
   wire [1:0] int_set = {settle_rise, alarm_hit};
   wire [1:0] int_clr = wr_int ? wdata_i[1:0] : 2'b00;
   // Set wins over the write-one clear
   assign int_stat_next = int_set | (int_stat_reg & ~int_clr);

   // ------------------------------------------------------------
   // Pin short control
   // ------------------------------------------------------------
   // Only the two pin codes move the short; other values are just kept
   // The stored byte reads back as written, so software can tell which
   // code it left behind.
   assign short_next = (wr_pin && wdata_i == rtc_regs_pkg::PIN_SHORT_CODE)
                       ? 1'b1                                   // RL5
                       : (wr_pin
                          && wdata_i == rtc_regs_pkg::PIN_NORMAL_CODE)
                       ? 1'b0                                   // RL6
                       : short_reg;

   // ------------------------------------------------------------
   // Read mux
   // ------------------------------------------------------------
   // Reads have no side effects; status bits clear only on a write,
   // so a polling loop cannot lose an event.
   wire [7:0] cfg_rd = {step_en_reg, settled, 2'b00, target_reg}; // RL4
   wire [7:0] ctrl_rd = {3'b000, run_reg, wake_en_reg, alarm_reg,
                         load_cmd_reg, snap_cmd_reg};

   always_comb begin
      rdata_next = rtc_regs_pkg::BYTE_ZERO;
      if (rd_i) begin
         unique case (addr_i)
            rtc_regs_pkg::ADDR_SNAP0:    rdata_next = snap_reg[7:0];
            rtc_regs_pkg::ADDR_SNAP1:    rdata_next = snap_reg[15:8];
            rtc_regs_pkg::ADDR_SNAP2:    rdata_next = snap_reg[23:16];
            rtc_regs_pkg::ADDR_SNAP3:    rdata_next = snap_reg[31:24];
            rtc_regs_pkg::ADDR_CTRL:     rdata_next = ctrl_rd;
            rtc_regs_pkg::ADDR_INT:      rdata_next = {6'b0, int_stat_reg};
            rtc_regs_pkg::ADDR_OSC_CFG:  rdata_next = cfg_rd;   // RL2
            rtc_regs_pkg::ADDR_PIN_CFG:  rdata_next = pin_cfg_reg;
            rtc_regs_pkg::ADDR_WAKE0:    rdata_next = wake_reg[7:0];
            rtc_regs_pkg::ADDR_WAKE1:    rdata_next = wake_reg[15:8];
            rtc_regs_pkg::ADDR_WAKE2:    rdata_next = wake_reg[23:16];
            rtc_regs_pkg::ADDR_WAKE3:    rdata_next = wake_reg[31:24];
            rtc_regs_pkg::ADDR_INT_MASK: rdata_next = {6'b0, int_mask_reg};
            default:                     rdata_next = rtc_regs_pkg::BYTE_ZERO;
         endcase
      end
   end

   // ------------------------------------------------------------
   // Data path registers
   // ------------------------------------------------------------
   // Timer stops at reset and waits for run; a load needs no run
   always_ff @(posedge clk_i) begin
      if (!rst_b_i) begin
         snap_reg  <= rtc_regs_pkg::WORD_ZERO;                  // RL7
         wake_reg  <= rtc_regs_pkg::WORD_ZERO;                  // RL9
         timer_reg <= rtc_regs_pkg::WORD_ZERO;
         rdata_reg <= rtc_regs_pkg::BYTE_ZERO;
      end else begin
         snap_reg  <= snap_next;
         wake_reg  <= wake_next;
         timer_reg <= timer_next;
         rdata_reg <= rdata_next;
      end
   end

   // Configuration; reserved config bits are never stored
   always_ff @(posedge clk_i) begin
      if (!rst_b_i) begin
         step_en_reg <= 1'b0;
         target_reg  <= rtc_regs_pkg::CAP_TARGET_RST;
         pin_cfg_reg <= rtc_regs_pkg::PIN_NORMAL_CODE;
         short_reg   <= 1'b0;
      end else begin
         if (wr_cfg) begin
            step_en_reg <= wdata_i[rtc_regs_pkg::CFG_STEP_EN_BIT]; // RL1
            target_reg  <= wdata_i[3:0];                        // RL3
         end
         if (wr_pin) begin
            pin_cfg_reg <= wdata_i;
         end
         short_reg <= short_next;
      end
   end

   // Control, commands and interrupt state
   // Command flags are rewritten every cycle, so each lasts one cycle
   always_ff @(posedge clk_i) begin
      if (!rst_b_i) begin
         run_reg       <= 1'b0;
         wake_en_reg   <= 1'b0;
         load_cmd_reg  <= 1'b0;
         snap_cmd_reg  <= 1'b0;
         alarm_reg     <= 1'b0;
         int_stat_reg  <= 2'b00;
         int_mask_reg  <= 2'b00;
         // Starts at the live value, so leaving reset makes no edge
         settled_d_reg <= (rtc_regs_pkg::CAP_TARGET_RST
                           == rtc_regs_pkg::CAP_STEP_RST);
      end else begin
         if (wr_ctrl) begin
            run_reg     <= wdata_i[rtc_regs_pkg::CTRL_RUN_BIT];
            wake_en_reg <= wdata_i[rtc_regs_pkg::CTRL_WAKE_EN_BIT];
         end
         if (wr_mask) begin
            int_mask_reg <= wdata_i[1:0];
         end
         load_cmd_reg  <= load_cmd_next;
         snap_cmd_reg  <= snap_cmd_next;
         alarm_reg     <= alarm_next;
         int_stat_reg  <= int_stat_next;
         settled_d_reg <= settled;
      end
   end

   // ------------------------------------------------------------
   // Outputs
   // ------------------------------------------------------------
   assign rdata_o       = rdata_reg;
   assign cap_value_o   = cap_now;
   assign xtal_short_o  = short_reg;                            // RL5 RL6
   assign timer_count_o = timer_reg;
   assign alarm_o       = alarm_reg;
   // Level from flops only, so a status change and a mask write in one
   // cycle cannot glitch the line
   assign irq_o         = |(int_stat_reg & int_mask_reg);

endmodule : rtc_osc_cfg_capture_alarm

// >>> dv/rtc_osc_cfg_capture_alarm_props.sv
`timescale 1ns/1ps
// ---------------------------------------------------------------
// Port checks; shadows rebuilt from host traffic
// ---------------------------------------------------------------
module rtc_regs_chk (
   // Clock and reset
   input  wire logic        clk_i,
   input  wire logic        rst_b_i,
   // Register port
   input  wire logic [3:0]  addr_i,
   input  wire logic [7:0]  wdata_i,
   input  wire logic        wr_i,
   input  wire logic        rd_i,
   input  wire logic [7:0]  rdata_o,
   // Outputs watched
   input  wire logic [3:0]  cap_value_o,
   input  wire logic        xtal_short_o,
   input  wire logic [31:0] timer_count_o,
   input  wire logic        alarm_o,
   input  wire logic        irq_o
);
   wire logic  ctl_wr = wr_i && addr_i == rtc_regs_pkg::ADDR_CTRL;
   wire logic  pin_wr = wr_i && addr_i == rtc_regs_pkg::ADDR_PIN_CFG;
   logic [31:0] snap_reg;
   logic [31:0] wake_reg;
   logic        snap_pend_reg;
   logic        wake_en_reg;

   // A capture must win over host bytes, as in the block itself
   always_ff @(posedge clk_i) begin
      if (!rst_b_i) begin
         snap_reg      <= 32'h0000_0000;
         wake_reg      <= 32'h0000_0000;
         snap_pend_reg <= 1'b0;
         wake_en_reg   <= 1'b0;
      end else begin
         snap_pend_reg <= ctl_wr && wdata_i[rtc_regs_pkg::CTRL_SNAP_BIT];
         if (snap_pend_reg) begin
            snap_reg <= timer_count_o;
         end else if (wr_i && addr_i[3:2] == 2'b00) begin
            snap_reg[addr_i[1:0]*8 +: 8] <= wdata_i;
         end
         if (wr_i && addr_i[3:2] == 2'b10) begin
            wake_reg[addr_i[1:0]*8 +: 8] <= wdata_i;
         end
         if (ctl_wr) begin
            wake_en_reg <= wdata_i[rtc_regs_pkg::CTRL_WAKE_EN_BIT];
         end
      end
   end

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rst_b_i);

   // ---------------------------------------------------------------
   // Sequences and assertions
   // ---------------------------------------------------------------
   sequence s_load;
      ctl_wr && wdata_i[1] && !wdata_i[0];
   endsequence
   sequence s_wake_hit;
      wake_en_reg && !ctl_wr && timer_count_o == wake_reg;
   endsequence

   a_rdata_idle: assert property (!rd_i |=> rdata_o == 8'h00)
      else $error("read data not zero outside a read");
   a_unmapped_read: assert property (
      rd_i && addr_i > rtc_regs_pkg::ADDR_INT_MASK |=> rdata_o == 8'h00)
      else $error("unmapped read not zero");
   a_osc_unused: assert property (
      rd_i && addr_i == rtc_regs_pkg::ADDR_OSC_CFG |=> rdata_o[5:4] == 2'b00)
      else $error("unused config bits read nonzero");
   a_short_code: assert property (
      pin_wr && wdata_i == rtc_regs_pkg::PIN_SHORT_CODE |=> xtal_short_o)
      else $error("pins not shorted");
   a_normal_code: assert property (
      pin_wr && wdata_i == rtc_regs_pkg::PIN_NORMAL_CODE |=> !xtal_short_o)
      else $error("pins not restored");
   a_short_hold: assert property (
      !(pin_wr && (wdata_i == 8'he7 || wdata_i == 8'h67))
      |=> $stable(xtal_short_o))
      else $error("pin short changed without a code");
   a_cap_step: assert property ($changed(cap_value_o) |->
      (cap_value_o - $past(cap_value_o) == 4'h1) ||
      ($past(cap_value_o) - cap_value_o == 4'h1))
      else $error("capacitance jumped more than one code");
   a_load_walk: assert property (
      s_load |-> ##2 timer_count_o == snap_reg)
      else $error("timer not loaded from snapshot");
   a_alarm_match: assert property (s_wake_hit |-> ##[1:2] alarm_o)
      else $error("alarm missed on match");
   a_alarm_clear: assert property (
      ctl_wr && !wdata_i[3] |=> !alarm_o)
      else $error("alarm stayed after disable");
endmodule : rtc_regs_chk

bind rtc_osc_cfg_capture_alarm rtc_regs_chk u_chk (
   .clk_i(clk_i), .rst_b_i(rst_b_i), .addr_i(addr_i), .wdata_i(wdata_i),
   .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .cap_value_o(cap_value_o),
   .xtal_short_o(xtal_short_o), .timer_count_o(timer_count_o),
   .alarm_o(alarm_o), .irq_o(irq_o));

// >>> dv/rtc_osc_cfg_capture_alarm_tb.sv
`timescale 1ns/1ps
module rtc_osc_cfg_capture_alarm_tb;
   // ---------------------------------------------------------------
   // Stimulus and observed signals
   // ---------------------------------------------------------------
   logic        clk_i   = 1'b0;
   logic        rst_b_i = 1'b0;
   logic [3:0]  addr_i  = 4'h0;
   logic [7:0]  wdata_i = 8'h00;
   logic        wr_i    = 1'b0;
   logic        rd_i    = 1'b0;
   logic [7:0]  rdata_o;
   logic [3:0]  cap_value_o;
   logic        xtal_short_o;
   logic        alarm_o;
   logic        irq_o;
   logic [31:0] timer_count_o;
   int          error_cnt   = 0;
   int          check_count = 0;
   int          i;

   always #20 clk_i = ~clk_i;

   rtc_osc_cfg_capture_alarm dut (
      .clk_i(clk_i), .rst_b_i(rst_b_i), .addr_i(addr_i), .wdata_i(wdata_i),
      .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .cap_value_o(cap_value_o),
      .xtal_short_o(xtal_short_o), .timer_count_o(timer_count_o),
      .alarm_o(alarm_o), .irq_o(irq_o));

   // ---------------------------------------------------------------
   // Bus and compare tasks
   // ---------------------------------------------------------------
   task automatic chk(input string n, input logic [31:0] s, e);
      check_count++;
      if (s !== e) begin
         error_cnt++;
         $display("[FAIL] %s exp %h seen %h", n, e, s);
      end
   endtask : chk

   // Strobe drops at the edge, next call raises it 1 ns later
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      addr_i  <= a;
      wdata_i <= d;
      wr_i    <= 1'b1;
      @(posedge clk_i);
      wr_i <= 1'b0;
      #1;
   endtask : wr

   // Read data stands only in the cycle after the strobe
   task automatic rc(input logic [3:0] a, input logic [7:0] e);
      addr_i <= a;
      rd_i   <= 1'b1;
      @(posedge clk_i);
      rd_i <= 1'b0;
      #1;
      chk($sformatf("read %h", a), {24'h0, rdata_o}, {24'h0, e});
   endtask : rc

   task automatic final_report();
      $display("checks %0d mismatches %0d", check_count, error_cnt);
      if (error_cnt == 0 && check_count > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : final_report

   // ---------------------------------------------------------------
   // Main sequence
   // ---------------------------------------------------------------
   initial begin
      repeat (8) @(posedge clk_i);
      rst_b_i <= 1'b1;
      @(posedge clk_i);
      // Reset map, status too: no settled edge may follow reset
      for (i = 0; i < 16; i++) begin
         rc(i[3:0], (i == 6) ? 8'h40 : (i == 7) ? 8'h67 : 8'h00);
      end
      wr(4'hd, 8'hff);
      rc(4'hd, 8'h00);
      // Stepping up to the top code, then frozen when disabled
      wr(4'h6, 8'hbf);
      rc(4'h6, 8'h8f);
      for (i = 0; i < 100 && cap_value_o !== 4'hf; i++) @(negedge clk_i);
      chk("cap", {28'h0, cap_value_o}, 32'hf);
      if (i == 100) final_report();
      rc(4'h6, 8'hcf);
      wr(4'h6, 8'h03);
      repeat (12) @(posedge clk_i);
      chk("cap held", {28'h0, cap_value_o}, 32'hf);
      rc(4'h6, 8'h03);
      // Pin codes; another value is stored but changes nothing
      wr(4'h7, 8'he7);
      chk("short", {31'h0, xtal_short_o}, 32'h1);
      wr(4'h7, 8'h12);
      chk("short kept", {31'h0, xtal_short_o}, 32'h1);
      rc(4'h7, 8'h12);
      wr(4'h7, 8'h67);
      chk("normal", {31'h0, xtal_short_o}, 32'h0);
      // Load, run eleven cycles, stop and capture
      for (i = 0; i < 4; i++) wr(i[3:0], 8'h78 - 8'h22 * i[7:0]);
      wr(4'h4, 8'h02);
      repeat (2) @(posedge clk_i);
      chk("loaded", timer_count_o, 32'h1234_5678);
      rc(4'h4, 8'h00);
      wr(4'h4, 8'h10);
      repeat (10) @(posedge clk_i);
      wr(4'h4, 8'h01);
      // Snapshot flag stands for the one cycle of the move
      rc(4'h4, 8'h01);
      rc(4'h4, 8'h00);
      for (i = 0; i < 4; i++) begin
         rc(i[3:0], 8'(32'h1234_5683 >> (8 * i)));
      end
      // Compare update with the alarm off, then armed
      wr(4'h4, 8'h00);
      // Compare word 0x1234_5690, eight counts past the reloaded timer
      wr(4'h8, 8'h90);
      for (i = 9; i < 12; i++) begin
         wr(i[3:0], 8'h78 - 8'h22 * (i[7:0] - 8'h8));
      end
      rc(4'hb, 8'h12);
      wr(4'h0, 8'h88);
      wr(4'h4, 8'h02);
      wr(4'hc, 8'h01);
      wr(4'h4, 8'h18);
      for (i = 0; i < 40 && alarm_o !== 1'b1; i++) @(negedge clk_i);
      chk("alarm", {31'h0, alarm_o}, 32'h1);
      if (i == 40) final_report();
      chk("irq", {31'h0, irq_o}, 32'h1);
      rc(4'h4, 8'h1c);
      wr(4'hc, 8'h00);
      chk("irq masked", {31'h0, irq_o}, 32'h0);
      wr(4'hc, 8'h01);
      chk("irq unmasked", {31'h0, irq_o}, 32'h1);
      wr(4'h4, 8'h10);
      chk("alarm off", {31'h0, alarm_o}, 32'h0);
      wr(4'h5, 8'h01);
      chk("irq cleared", {31'h0, irq_o}, 32'h0);
      // Settled event from the earlier walk stays, alarm bit is gone
      rc(4'h5, 8'h02);
      // Reset in mid-run brings back the defaults
      wr(4'h7, 8'he7);
      rst_b_i <= 1'b0;
      repeat (3) @(posedge clk_i);
      rst_b_i <= 1'b1;
      @(posedge clk_i);
      #1;
      chk("timer rst", timer_count_o, 32'h0);
      chk("short rst", {31'h0, xtal_short_o}, 32'h0);
      rc(4'h7, 8'h67);
      final_report();
   end
endmodule : rtc_osc_cfg_capture_alarm_tb
